// *** logic/sem_status_unit.sv ***
// Semaphore status, ownership bitmaps, fault record and re-arm over APB.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Query bits 31..16 read zero and ignore writes.
// RULE2 - Query owner field shows holder while taken, zero while free.
// RULE3 - Query read shows grant state in bit 0, never grants.
// RULE4 - Query write 0 requests the semaphore, write 1 releases it.
// RULE5 - Per-master bitmap bit y is one while that master holds y.
// RULE6 - Each core has its own bitmap and set register.
// RULE7 - Writing one to a bitmap bit clears it.
// RULE8 - Writing one to a set register bit sets the bitmap bit.
// RULE9 - Fault record captures every acquire or release fault.
// RULE10 - Fault record bits 15..8 hold the offending master.
// RULE11 - Fault record bits 7..3 hold the semaphore index.
// RULE12 - Fault code reads 000 while no fault is recorded.
// RULE13 - Releasing a free semaphore records code 001.
// RULE14 - Releasing a semaphore held by another master records 010.
// RULE15 - Acquiring a semaphore already held by itself records 011.
// RULE16 - Acquiring with own request already pending records 100.
// RULE17 - Writing the fault clear register erases the fault code.
// RULE18 - Software clears the fault then writes the re-arm register.
// RULE19 - Reading a query register leaves the semaphore unchanged.
// RULE20 - Re-arm 0x10 enables error line, 0..2 enable core lines.
// RULE21 - Error line fires once per fault until re-armed.
module sem_status_unit
  import sem_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // APB slave port.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Number of the master issuing the current transfer.
  input  wire sem_pkg::master_t   requesterId,
  // Event lines.
  output logic                    errIrq,
  output logic [NUM_MASTERS-1:0]  semIrq
);
  import sem_pkg::*;

  typedef struct packed {
    phase_e                             phase;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
    logic [NUM_SEM-1:0]                 taken;
    logic [NUM_MASTERS-1:0][NUM_SEM-1:0] flags;
    logic [NUM_MASTERS-1:0][NUM_SEM-1:0] pend;
    logic                               errArm;
    logic [NUM_MASTERS-1:0]             semArm;
    logic                               errIrq;
    logic [NUM_MASTERS-1:0]             semIrq;
  } state_s;

  state_s q;
  state_s d;

  // Address window check for an array of word registers.
  function automatic logic inRange(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input int n);
    inRange = (a >= base) && (32'(a) < 32'(base) + 4 * n) &&
              (a[1:0] == 2'b00);
  endfunction : inRange

  // Word index within such an array.
  function automatic sem_idx_t regIdx(input logic [11:0] a,
                                      input logic [11:0] base);
    logic [11:0] diff;
    diff = a - base;
    regIdx = diff[6:2];
  endfunction : regIdx

  logic        hitQuery;
  logic        hitFlag;
  logic        hitFlagSet;
  logic        hitFault;
  logic        hitFaultClr;
  logic        hitRearm;
  logic        mapped;
  sem_idx_t    idx;
  logic [1:0]  mIdx;
  logic        idOk;
  logic        doneWr;
  logic [7:0]  ownRd;
  logic [15:0] faultRec;
  logic        recEv;
  logic [2:0]  recCode;
  logic        memWe;
  master_t     memWd;

  // Decode is held steady by the master for the whole transfer.
  assign hitQuery    = inRange(paddr, OFS_QUERY, NUM_SEM);
  assign hitFlag     = inRange(paddr, OFS_FLAG, NUM_MASTERS);  // see RULE6
  assign hitFlagSet  = inRange(paddr, OFS_FLAGSET, NUM_MASTERS);
  assign hitFault    = (paddr == OFS_FAULT);
  assign hitFaultClr = (paddr == OFS_FAULTCLR);
  assign hitRearm    = (paddr == OFS_REARM);
  assign mapped      = hitQuery | hitFlag | hitFlagSet | hitFault |
                       hitFaultClr | (hitRearm & pwrite);
  assign idx         = hitQuery ? regIdx(paddr, OFS_QUERY) :
                       hitFlag ? regIdx(paddr, OFS_FLAG) :
                       regIdx(paddr, OFS_FLAGSET);
  assign mIdx        = requesterId[1:0];
  assign idOk        = requesterId < 8'(NUM_MASTERS);
  assign doneWr      = (q.phase == PH_DONE) && psel && penable && pwrite;

  // The owner table is read during setup so data is ready in access.
  sem_owner_mem u_owner (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .rdAddr  (idx),
    .rdData  (ownRd),
    .wrEn    (memWe),
    .wrAddr  (idx),
    .wrData  (memWd)
  );

  fault_record u_fault (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .capture   (recEv),
    .masterNum (requesterId),
    .semIdx    (idx),
    .code      (recCode),
    .clear     (doneWr & hitFaultClr),  // see RULE17
    .record    (faultRec)
  );

  // Transfer phases, register reads and every write side effect except the fault clear.
  always_comb begin
    logic            found;
    logic [1:0]      nxt;
    logic [31:0]     rd;
    found   = 1'b0;
    nxt     = 2'd0;
    rd      = '0;
    d       = q;
    d.errIrq = 1'b0;
    d.semIrq = '0;
    recEv   = 1'b0;
    recCode = ERR_NONE;
    memWe   = 1'b0;
    memWd   = requesterId;
    case (q.phase)
      PH_IDLE: begin
        if (psel && !penable) begin
          d.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        // Reads have no side effect on any semaphore.  see RULE19
        if (hitQuery) begin
          rd[OWNER_MSB:OWNER_LSB] = q.taken[idx] ? ownRd : 8'h00;  // see RULE2
          rd[GRANT_BIT] = ~q.taken[idx];  // see RULE3
        end else if (hitFlag) begin
          rd = q.flags[idx[1:0]];  // see RULE5
        end else if (hitFault) begin
          rd[15:0] = faultRec;  // see RULE12
        end
        d.prdata  = pwrite ? 32'h0000_0000 : rd;  // see RULE1
        d.pslverr = ~mapped;
        d.pready  = 1'b1;
        d.phase   = PH_DONE;
      end
      PH_DONE: begin
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = '0;
        d.phase   = PH_IDLE;
        if (doneWr && hitQuery && pwdata[GRANT_BIT]) begin
          // Release; only bit 0 of the word matters.  see RULE4
          if (!q.taken[idx]) begin
            recEv   = 1'b1;
            recCode = ERR_FREE_IDLE;  // see RULE13
          end else if (ownRd != requesterId) begin
            recEv   = 1'b1;
            recCode = ERR_NOT_OWNER;  // see RULE14
          end else begin
            if (idOk) begin
              d.flags[mIdx][idx] = 1'b0;
            end
            // Fixed priority hand-over to the lowest pending core.
            for (int m = NUM_MASTERS - 1; m >= 0; m--) begin
              if (q.pend[m][idx]) begin
                found = 1'b1;
                nxt   = 2'(m);
              end
            end
            if (found) begin
              d.pend[nxt][idx]  = 1'b0;
              d.flags[nxt][idx] = 1'b1;
              memWe             = 1'b1;
              memWd             = {6'h00, nxt};
              if (q.semArm[nxt]) begin
                d.semIrq[nxt] = 1'b1;
                d.semArm[nxt] = 1'b0;
              end
            end else begin
              d.taken[idx] = 1'b0;
            end
          end
        end else if (doneWr && hitQuery) begin
          // Acquisition request.  see RULE4
          if (q.taken[idx] && ownRd == requesterId) begin
            recEv   = 1'b1;
            recCode = ERR_ALREADY_HELD;  // see RULE15
          end else if (idOk && q.pend[mIdx][idx]) begin
            recEv   = 1'b1;
            recCode = ERR_DUP_PEND;  // see RULE16
          end else if (!q.taken[idx]) begin
            d.taken[idx] = 1'b1;
            memWe        = 1'b1;
            if (idOk) begin
              d.flags[mIdx][idx] = 1'b1;
              if (q.semArm[mIdx]) begin
                d.semIrq[mIdx] = 1'b1;
                d.semArm[mIdx] = 1'b0;
              end
            end
          end else if (idOk) begin
            d.pend[mIdx][idx] = 1'b1;
          end
        end
        if (doneWr && hitFlag) begin
          d.flags[idx[1:0]] = q.flags[idx[1:0]] & ~pwdata;  // see RULE7
        end
        if (doneWr && hitFlagSet) begin
          d.flags[idx[1:0]] = q.flags[idx[1:0]] | pwdata;  // see RULE8
        end
        if (doneWr && hitRearm) begin
          if (pwdata[7:0] == SEL_ERR_REARM) begin
            d.errArm = 1'b1;  // see RULE20
          end else if (pwdata[7:0] < 8'(NUM_MASTERS)) begin
            d.semArm[pwdata[1:0]] = 1'b1;  // see RULE20
          end
        end
        // One pulse per fault, then silent until re-armed.
        if (recEv && q.errArm) begin
          d.errIrq = 1'b1;  // see RULE21
          d.errArm = 1'b0;
        end
      end
      default: begin
        d.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q        <= '0;
      q.errArm <= 1'b1;
      q.semArm <= '1;
    end else begin
      q <= d;
    end
  end

  // All outputs come straight from the state register.
  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign errIrq  = q.errIrq;
  assign semIrq  = q.semIrq;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_QUERY_RSVD: assert property ( // see RULE1
    (q.pready && hitQuery && !pwrite) |->
      (prdata[31:16] == 16'h0000 && prdata[7:1] == 7'h00))
    else $error("query reserved bits not zero");
  AST_OWNER_FREE: assert property ( // see RULE2
    (q.pready && hitQuery && !pwrite && prdata[GRANT_BIT]) |->
      prdata[OWNER_MSB:OWNER_LSB] == 8'h00)
    else $error("owner shown for free semaphore");
  AST_READ_KEEPS: assert property ( // see RULE19
    (q.phase == PH_DONE && psel && penable && !pwrite) |=>
      (q.taken == $past(q.taken) && q.pend == $past(q.pend)))
    else $error("read changed semaphore state");
  AST_ACQ_FREE: assert property ( // see RULE4
    (doneWr && hitQuery && !pwdata[0] && !q.taken[idx] && idOk) |=>
      (q.taken[$past(idx)] && q.flags[$past(mIdx)][$past(idx)]))
    else $error("free semaphore not granted");
  AST_REL_FREE: assert property ( // see RULE13
    (doneWr && hitQuery && pwdata[0] && !q.taken[idx]) |=>
      (faultRec[2:0] == ERR_FREE_IDLE && faultRec[7:3] == $past(idx)))
    else $error("release of free semaphore not recorded");
  AST_DUP_PEND: assert property ( // see RULE16
    (doneWr && hitQuery && !pwdata[0] && idOk && q.pend[mIdx][idx] &&
     !(q.taken[idx] && ownRd == requesterId)) |=>
      faultRec == {$past(requesterId), $past(idx), ERR_DUP_PEND})
    else $error("duplicate request not recorded");
  AST_FLAG_W1C: assert property ( // see RULE7
    (doneWr && hitFlag) |=>
      (q.flags[$past(idx[1:0])] & $past(pwdata)) == 32'h0000_0000)
    else $error("ownership bit not cleared");
  AST_FLAG_W1S: assert property ( // see RULE8
    (doneWr && hitFlagSet) |=>
      (q.flags[$past(idx[1:0])] & $past(pwdata)) == $past(pwdata))
    else $error("ownership bit not set");
  AST_FAULT_CLR: assert property ( // see RULE17
    (doneWr && hitFaultClr) |=> faultRec[2:0] == ERR_NONE)
    else $error("fault code not erased");
  AST_ERR_ONCE: assert property ( // see RULE21
    errIrq |-> (faultRec[2:0] != ERR_NONE) ##1 (!errIrq && !q.errArm))
    else $error("error line fired twice or without fault");
endmodule : sem_status_unit

// *** logic/sem_pkg.sv ***
// Shared constants and types for the semaphore status and fault block.
package sem_pkg;
  // Sizes of the semaphore array and of the core population.
  localparam int NUM_SEM     = 32;
  localparam int NUM_MASTERS = 3;
  localparam int ADDR_W      = 12;

  // Byte offsets of the registers on the APB port.
  localparam logic [11:0] OFS_REARM    = 12'h00c;
  localparam logic [11:0] OFS_QUERY    = 12'h300;
  localparam logic [11:0] OFS_FLAG     = 12'h400;
  localparam logic [11:0] OFS_FLAGSET  = 12'h480;
  localparam logic [11:0] OFS_FAULT    = 12'h500;
  localparam logic [11:0] OFS_FAULTCLR = 12'h504;

  // Field positions shared by the query word and the fault record.
  localparam int OWNER_LSB  = 8;
  localparam int OWNER_MSB  = 15;
  localparam int SEMIDX_LSB = 3;
  localparam int SEMIDX_MSB = 7;
  localparam int CODE_MSB   = 2;
  localparam int GRANT_BIT  = 0;

  // Re-arm select value for the shared error line.
  localparam logic [7:0] SEL_ERR_REARM = 8'h10;

  // Fault codes.
  localparam logic [2:0] ERR_NONE         = 3'h0;
  localparam logic [2:0] ERR_FREE_IDLE    = 3'h1;
  localparam logic [2:0] ERR_NOT_OWNER    = 3'h2;
  localparam logic [2:0] ERR_ALREADY_HELD = 3'h3;
  localparam logic [2:0] ERR_DUP_PEND     = 3'h4;

  typedef logic [7:0] master_t;
  typedef logic [4:0] sem_idx_t;

  // APB slave phases, Gray coded along IDLE, WAIT, DONE.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_DONE = 2'b11
  } phase_e;
endpackage : sem_pkg

// *** logic/sem_owner_mem.sv ***
// Owner table: one master number per semaphore, registered read port.
`timescale 1ns/1ps
module sem_owner_mem
  import sem_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // Read port.
  input  wire sem_pkg::sem_idx_t  rdAddr,
  output logic [7:0]              rdData,
  // Write port.
  input  wire logic               wrEn,
  input  wire sem_pkg::sem_idx_t  wrAddr,
  input  wire sem_pkg::master_t   wrData
);
  typedef struct packed {
    logic [NUM_SEM-1:0][7:0] mem;
    logic [7:0]              rd;
  } mem_s;

  mem_s q;
  mem_s d;

  // Read data always comes out of a register, one cycle after the address.
  always_comb begin
    d = q;
    d.rd = q.mem[rdAddr];
    if (wrEn) begin
      d.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdData = q.rd;
endmodule : sem_owner_mem

// *** logic/fault_record.sv ***
// Access fault record: offending master, semaphore index and fault code.
`timescale 1ns/1ps
module fault_record
  import sem_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // Capture of a new fault.
  input  wire logic               capture,
  input  wire sem_pkg::master_t   masterNum,
  input  wire sem_pkg::sem_idx_t  semIdx,
  input  wire logic [2:0]         code,
  // Software clear of the code.
  input  wire logic               clear,
  output logic [15:0]             record
);
  typedef struct packed {
    logic [15:0] rec;
  } rec_s;

  rec_s q;
  rec_s d;

  // A fault in the clear cycle wins, so it is never lost.
  always_comb begin
    d = q;
    if (capture) begin
      d.rec = {masterNum, semIdx, code};  // see RULE9 RULE10 RULE11
    end else if (clear) begin
      d.rec[CODE_MSB:0] = ERR_NONE;  // see RULE17
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign record = q.rec;
endmodule : fault_record

// *** verification/apb_core_model.sv ***
// APB master model that stands in for the processor cores.
`timescale 1ns/1ps
module apb_core_model (
  // Clock.
  input  wire logic             clk_sys,
  // APB master side.
  output logic                  psel,
  output logic                  penable,
  output logic                  pwrite,
  output logic [11:0]           paddr,
  output logic [31:0]           pwdata,
  input  wire logic [31:0]      prdata,
  input  wire logic             pready,
  input  wire logic             pslverr,
  // Number of the core that owns the transfer.
  output sem_pkg::master_t      requesterId
);
  import sem_pkg::*;

  // The bus starts idle with nothing selected.
  initial begin
    psel        = 1'h0;
    penable     = 1'h0;
    pwrite      = 1'h0;
    paddr       = 12'h0;
    pwdata      = 32'h0;
    requesterId = 8'h0;
  end

  // One transfer: setup, access held until pready is seen at an edge.
  task automatic xfer(input logic wr, input master_t id,
                      input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel        <= 1'h1;
    pwrite      <= wr;
    paddr       <= a;
    pwdata      <= wd;
    requesterId <= id;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // Released lines must not keep showing the old request.
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask : xfer
endmodule : apb_core_model

// *** verification/tb_top.sv ***
// Self-checking bench for the semaphore status and fault block.
`timescale 1ns/1ps
module tb_top;
  import sem_pkg::*;
  logic                   clk_sys;
  logic                   reset_n;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  master_t                requesterId;
  logic                   errIrq;
  logic [NUM_MASTERS-1:0] semIrq;
  logic [31:0]            rd;
  logic                   er;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  int                     errCnt = 0;
  int                     semCnt [NUM_MASTERS] = '{default: 0};

  sem_status_unit u_sem_status_unit (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .requesterId(requesterId),
    .errIrq(errIrq), .semIrq(semIrq));

  apb_core_model u_apb_core_model (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .requesterId(requesterId));

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Count event pulses; a pulse stands one cycle, so each edge counts once.
  always @(posedge clk_sys) begin
    if (errIrq === 1'h1) errCnt++;
    for (int i = 0; i < NUM_MASTERS; i++)
      if (semIrq[i] === 1'h1) semCnt[i]++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] at(input logic [11:0] b, input int n);
    return b + 12'(4 * n);
  endfunction : at

  task automatic wr(input master_t id, input logic [11:0] a,
                    input logic [31:0] d);
    u_apb_core_model.xfer(1'h1, id, a, d, rd, er);
  endtask : wr

  task automatic rdchk(input master_t id, input logic [11:0] a,
                       input logic [31:0] exp);
    u_apb_core_model.xfer(1'h0, id, a, 32'h0, rd, er);
    check(rd, exp);
  endtask : rdchk

  // Out of reset semaphore 0 is free, core 0 holds nothing and nothing is recorded.
  task automatic t_reset();
    rdchk(8'h0, at(OFS_QUERY, 0), 32'h1);
    rdchk(8'h0, OFS_FAULT, 32'h0);
    rdchk(8'h0, at(OFS_FLAG, 0), 32'h0);
  endtask : t_reset

  // Grant on a free semaphore; junk in the upper bits must be ignored.
  task automatic t_acquire();
    wr(8'h1, at(OFS_QUERY, 5), 32'hffff_0000);
    rdchk(8'h0, at(OFS_QUERY, 5), 32'h100);
    rdchk(8'h2, at(OFS_QUERY, 5), 32'h100);
    rdchk(8'h1, at(OFS_FLAG, 1), 32'h20);
    check(semCnt[1], 1);
  endtask : t_acquire

  // Cause one fault, read it, then clear and re-arm the error line.
  task automatic fault_case(input master_t id, input int s, input logic b,
                            input logic [2:0] c);
    int e;
    e = errCnt;
    wr(id, at(OFS_QUERY, s), {31'h0, b});
    rdchk(8'h0, OFS_FAULT, {16'h0, id, 5'(s), c});
    check(errCnt, e + 1);
    wr(8'h0, OFS_FAULTCLR, 32'h0);
    rdchk(8'h0, OFS_FAULT, {16'h0, id, 5'(s), 3'h0});
    wr(id, OFS_REARM, 32'h10);
  endtask : fault_case

  // Every fault code, then a second fault while the line is not re-armed.
  task automatic t_faults();
    int e;
    fault_case(8'h1, 5, 1'h0, 3'h3);
    fault_case(8'h2, 5, 1'h1, 3'h2);
    fault_case(8'h2, 7, 1'h1, 3'h1);
    wr(8'h2, at(OFS_QUERY, 5), 32'h0);
    rdchk(8'h0, OFS_FAULT, {16'h0, 8'h2, 5'h7, 3'h0});
    fault_case(8'h2, 5, 1'h0, 3'h4);
    e = errCnt;
    wr(8'h0, at(OFS_QUERY, 20), 32'h1);
    wr(8'h0, at(OFS_QUERY, 21), 32'h1);
    rdchk(8'h0, OFS_FAULT, {16'h0, 8'h0, 5'h15, 3'h1});
    check(errCnt, e + 1);
    wr(8'h0, OFS_FAULTCLR, 32'h0);
    wr(8'h0, OFS_REARM, 32'h10);
  endtask : t_faults

  // Release by the owner hands the semaphore to the pending core.
  task automatic t_handover();
    wr(8'h1, at(OFS_QUERY, 5), 32'h1);
    rdchk(8'h0, at(OFS_QUERY, 5), 32'h200);
    rdchk(8'h0, at(OFS_FLAG, 1), 32'h0);
    rdchk(8'h0, at(OFS_FLAG, 2), 32'h20);
    check(semCnt[2], 1);
  endtask : t_handover

  // Set and clear bits per core; the other cores must be untouched.
  task automatic t_bitmap();
    wr(8'h0, at(OFS_FLAGSET, 0), 32'ha5a5_0000);
    rdchk(8'h0, at(OFS_FLAG, 0), 32'ha5a5_0000);
    rdchk(8'h0, at(OFS_FLAG, 1), 32'h0);
    wr(8'h0, at(OFS_FLAGSET, 0), 32'h0);
    wr(8'h0, at(OFS_FLAG, 0), 32'h8000_0000);
    rdchk(8'h0, at(OFS_FLAG, 0), 32'h25a5_0000);
    wr(8'h2, at(OFS_FLAGSET, 2), 32'h1);
    rdchk(8'h0, at(OFS_FLAG, 2), 32'h21);
  endtask : t_bitmap

  // Core line stays quiet until re-armed with its own select value.
  task automatic t_rearm();
    wr(8'h1, at(OFS_QUERY, 9), 32'h0);
    repeat (2) @(posedge clk_sys);
    check(semCnt[1], 1);
    wr(8'h1, OFS_REARM, 32'h1);
    wr(8'h1, at(OFS_QUERY, 9), 32'h1);
    wr(8'h1, at(OFS_QUERY, 10), 32'h0);
    wr(8'h0, at(OFS_QUERY, 11), 32'h0);
    wr(8'h0, at(OFS_QUERY, 12), 32'h0);
    check(semCnt[0], 1);
    wr(8'h0, OFS_REARM, 32'h0);
    wr(8'h0, at(OFS_QUERY, 13), 32'h0);
    repeat (2) @(posedge clk_sys);
    check(semCnt[1], 2);
    check(semCnt[0], 2);
  endtask : t_rearm

  // Unmapped reads and writes answer with an error and zero data.
  task automatic t_unmapped();
    u_apb_core_model.xfer(1'h0, 8'h0, 12'h600, 32'h0, rd, er);
    check({rd[30:0], er}, 32'h1);
    wr(8'h0, 12'h600, 32'hffff_ffff);
    check({31'h0, er}, 32'h1);
    // The fault record answers a write without error but keeps its value.
    wr(8'h0, OFS_FAULT, 32'hffff_ffff);
    check({31'h0, er}, 32'h0);
    rdchk(8'h0, OFS_FAULT, {16'h0, 8'h0, 5'h15, 3'h0});
  endtask : t_unmapped

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    reset_n = 1'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_reset();
    t_acquire();
    t_faults();
    t_handover();
    t_bitmap();
    t_rearm();
    t_unmapped();
    print_verdict();
  end

  // The run needs well under a thousand cycles; a hang ends it here.
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule : tb_top
